// File: rtl/imp_pkg.sv
// package: register map, field positions and source numbering
package imp_pkg;

  // register addresses and page selection
  localparam logic [7:0] ADDR_ENABLE_MAIN   = 8'ha8;
  localparam logic [7:0] ADDR_PRIO_MAIN     = 8'hb8;
  localparam logic [7:0] ADDR_ENABLE_EXT1   = 8'he6;
  localparam logic [7:0] PAGE_PRIO_MAIN     = 8'h00;

  // bit addresses: register base plus bit number
  localparam logic [7:0] BIT_BASE_MASK      = 8'hf8;
  localparam logic [2:0] BIT_NUM_MASK       = 3'h7;

  // reset values and fixed read patterns
  localparam logic [7:0] RST_ENABLE_MAIN    = 8'h00;
  localparam logic [6:0] RST_PRIO_MAIN      = 7'h00;
  localparam logic [7:0] RST_ENABLE_EXT1    = 8'h00;
  localparam logic [7:0] PRIO_FIXED_ONES    = 8'h80;
  localparam logic [7:0] UNMAPPED_READ      = 8'h00;

  // enable main field positions
  localparam int unsigned GLOBAL_IRQ_GATE_BIT        = 7;
  localparam int unsigned SERIAL_PORT_ZERO_BIT       = 6;
  localparam int unsigned TIMER_TWO_BIT              = 5;
  localparam int unsigned UART_ZERO_BIT              = 4;
  localparam int unsigned TIMER_ONE_BIT              = 3;
  localparam int unsigned EXT_INPUT_ONE_BIT          = 2;
  localparam int unsigned TIMER_ZERO_BIT             = 1;
  localparam int unsigned EXT_INPUT_ZERO_BIT         = 0;

  // enable extended one field positions
  localparam int unsigned TIMER_THREE_BIT            = 7;
  localparam int unsigned COMPARATOR_ONE_BIT         = 6;
  localparam int unsigned COMPARATOR_ZERO_BIT        = 5;
  localparam int unsigned COUNTER_ARRAY_BIT          = 4;
  localparam int unsigned CONVERSION_DONE_BIT        = 3;
  localparam int unsigned WINDOW_COMPARE_BIT         = 2;
  localparam int unsigned CLOCK_ALARM_BIT            = 1;
  localparam int unsigned TWO_WIRE_BIT               = 0;

  // source numbers, also the fixed arbitration order (0 wins)
  localparam int unsigned NUM_SOURCES                = 15;
  localparam int unsigned SOURCE_ID_W                = 4;
  localparam int unsigned MAIN_SOURCES               = 7;
  localparam int unsigned EXT_SOURCES                = 8;

endpackage : imp_pkg

// File: rtl/imp_prio_pick.sv
// two-level priority pick with fixed order inside each level
`timescale 1ns/1ps
module imp_prio_pick #(
  parameter int unsigned N    = 15,
  parameter int unsigned ID_W = 4
) (
  // requests and their levels
  input  wire logic [N-1:0]    requests,
  input  wire logic [N-1:0]    high_level,
  // winner
  output logic                 valid,
  output logic [ID_W-1:0]      source_id,
  output logic                 is_high
);

  // lowest set index wins; used for both levels
  function automatic logic [ID_W-1:0] first_set(input logic [N-1:0] v);
    logic [ID_W-1:0] idx;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = ID_W'(i);
      end
    end
    return idx;
  endfunction : first_set

  logic [N-1:0] high_req;

  assign high_req = requests & high_level;

  always_comb begin
    valid     = |requests;
    is_high   = |high_req;
    if (is_high) begin
      source_id = first_set(high_req);
    end else begin
      source_id = first_set(requests);
    end
  end

endmodule : imp_prio_pick

// File: rtl/imp_regs_top.sv
// interrupt enable and priority registers with request gating
//
// Contract
// - global gate clear blocks every source
// - enable bit 6 gates serial port zero
// - enable bit 5 gates timer two flags
// - enable bit 4 gates the first uart
// - enable bit 3 gates timer one overflow
// - enable bit 2 gates external input one
// - enable bit 1 gates timer zero overflow
// - enable bit 0 gates external input zero
// - priority bit 7 reads one, ignores writes
// - priority bits 6..4 set level
// - priority bits 3..0 set level
// - extended bit 7 gates timer three flags
// - extended bit 6 gates comparator one edges
// - extended bit 5 gates comparator zero edges
// - extended bit 4 gates counter array
// - extended bit 3 gates conversion done
// - extended bit 2 gates window compare
// - extended bit 1 gates clock alarm
// - extended bit 0 gates two-wire bus
// - enable main at 0xa8, all pages, bits
// - priority at 0xb8, page zero, bits
// - extended enable at 0xe6, byte only
// - high level first, fixed order ties
// - requests sampled and decoded every cycle
`timescale 1ns/1ps
module imp_regs_top #(
  parameter int unsigned NUM_SRC = imp_pkg::NUM_SOURCES,
  parameter int unsigned ID_W    = imp_pkg::SOURCE_ID_W
) (
  // clock and reset
  input  wire logic                MCLK,
  input  wire logic                SYS_RST,
  // special-function byte access
  input  wire logic [7:0]          SFR_PAGE,
  input  wire logic [7:0]          SFR_ADDR,
  input  wire logic                SFR_WR_EN,
  input  wire logic [7:0]          SFR_WDATA,
  input  wire logic                SFR_RD_EN,
  output logic      [7:0]          SFR_RDATA,
  output logic                     SFR_HIT,
  // special-function single-bit access
  input  wire logic [7:0]          SFR_BIT_ADDR,
  input  wire logic                SFR_BIT_WR_EN,
  input  wire logic                SFR_BIT_WDATA,
  input  wire logic                SFR_BIT_RD_EN,
  output logic                     SFR_BIT_RDATA,
  output logic                     SFR_BIT_HIT,
  // main-group pending flags
  input  wire logic                EXT_IRQ_INPUT_ZERO,
  input  wire logic                TIMER_ZERO_OVERFLOW,
  input  wire logic                EXT_IRQ_INPUT_ONE,
  input  wire logic                TIMER_ONE_OVERFLOW,
  input  wire logic                FIRST_UART_FLAG,
  input  wire logic                TIMER_TWO_LOW_OVERFLOW,
  input  wire logic                TIMER_TWO_HIGH_OVERFLOW,
  input  wire logic                SERIAL_PORT_ZERO_FLAG,
  // extended-group pending flags
  input  wire logic                TWO_WIRE_BUS_PORT_FLAG,
  input  wire logic                CLOCK_ALARM_FLAG,
  input  wire logic                WINDOW_COMPARE_FLAG,
  input  wire logic                CONVERSION_DONE_FLAG,
  input  wire logic                COUNTER_ARRAY_FLAG,
  input  wire logic                COMPARATOR_ZERO_RISE_FLAG,
  input  wire logic                COMPARATOR_ZERO_FALL_FLAG,
  input  wire logic                COMPARATOR_ONE_RISE_FLAG,
  input  wire logic                COMPARATOR_ONE_FALL_FLAG,
  input  wire logic                TIMER_THREE_LOW_OVERFLOW,
  input  wire logic                TIMER_THREE_HIGH_OVERFLOW,
  // towards the cpu interrupt sequencer
  output logic      [NUM_SRC-1:0]  IRQ_REQUEST,
  output logic      [NUM_SRC-1:0]  IRQ_HIGH,
  output logic                     IRQ_VALID,
  output logic      [ID_W-1:0]     IRQ_SOURCE,
  output logic                     IRQ_HIGH_LEVEL,
  // register contents for the sequencer
  output logic      [7:0]          ENABLE_MAIN,
  output logic      [7:0]          PRIO_MAIN,
  output logic      [7:0]          ENABLE_EXT1
);

  typedef struct packed {
    logic [7:0]          enable_main;
    logic [6:0]          prio_main;
    logic [7:0]          enable_ext1;
    logic [7:0]          rdata;
    logic                hit;
    logic                bit_rdata;
    logic                bit_hit;
    logic [NUM_SRC-1:0]  request;
    logic [NUM_SRC-1:0]  high;
    logic                valid;
    logic [ID_W-1:0]     source;
    logic                high_level;
  } imp_state_type;

  imp_state_type state_q;
  imp_state_type state_d;

  // register select codes shared by byte and bit decoders
  localparam logic [1:0] SEL_NONE = 2'd0;
  localparam logic [1:0] SEL_EN   = 2'd1;
  localparam logic [1:0] SEL_PRIO = 2'd2;
  localparam logic [1:0] SEL_EXT1 = 2'd3;

  // byte decode; the priority register lives on one page only
  function automatic logic [1:0] byte_sel(input logic [7:0] addr,
                                          input logic [7:0] page);
    logic [1:0] sel;
    sel = SEL_NONE;
    if (addr == imp_pkg::ADDR_ENABLE_MAIN) begin
      sel = SEL_EN;
    end
    if (addr == imp_pkg::ADDR_PRIO_MAIN &&
        page == imp_pkg::PAGE_PRIO_MAIN) begin
      sel = SEL_PRIO;
    end
    if (addr == imp_pkg::ADDR_ENABLE_EXT1) begin
      sel = SEL_EXT1;
    end
    return sel;
  endfunction : byte_sel

  // bit decode; the extended enable has no bit addresses
  function automatic logic [1:0] bit_sel(input logic [7:0] baddr,
                                         input logic [7:0] page);
    logic [1:0] sel;
    logic [7:0] base;
    sel  = SEL_NONE;
    base = baddr & imp_pkg::BIT_BASE_MASK;
    if (base == imp_pkg::ADDR_ENABLE_MAIN) begin
      sel = SEL_EN;
    end
    if (base == imp_pkg::ADDR_PRIO_MAIN &&
        page == imp_pkg::PAGE_PRIO_MAIN) begin
      sel = SEL_PRIO;
    end
    return sel;
  endfunction : bit_sel

  logic [1:0]          wr_sel;
  logic [1:0]          rd_sel;
  logic [1:0]          bsel;
  logic [2:0]          bnum;
  logic [7:0]          prio_view;
  logic [7:0]          prio_next_view;
  logic [NUM_SRC-1:0]  raw_flags;
  logic [NUM_SRC-1:0]  src_masks;
  logic [NUM_SRC-1:0]  src_high;
  logic [NUM_SRC-1:0]  gated;
  logic                pick_valid;
  logic [ID_W-1:0]     pick_id;
  logic                pick_high;

  assign wr_sel = byte_sel(SFR_ADDR, SFR_PAGE);
  assign rd_sel = wr_sel;
  assign bsel   = bit_sel(SFR_BIT_ADDR, SFR_PAGE);
  assign bnum   = SFR_BIT_ADDR[2:0] & imp_pkg::BIT_NUM_MASK;

  assign prio_view = imp_pkg::PRIO_FIXED_ONES | {1'b0, state_q.prio_main};

  // pending flags in source order; two-flag sources are or-ed here
  always_comb begin
    raw_flags     = '0;
    raw_flags[0]  = EXT_IRQ_INPUT_ZERO;
    raw_flags[1]  = TIMER_ZERO_OVERFLOW;
    raw_flags[2]  = EXT_IRQ_INPUT_ONE;
    raw_flags[3]  = TIMER_ONE_OVERFLOW;
    raw_flags[4]  = FIRST_UART_FLAG;
    raw_flags[5]  = TIMER_TWO_LOW_OVERFLOW | TIMER_TWO_HIGH_OVERFLOW;
    raw_flags[6]  = SERIAL_PORT_ZERO_FLAG;
    raw_flags[7]  = TWO_WIRE_BUS_PORT_FLAG;
    raw_flags[8]  = CLOCK_ALARM_FLAG;
    raw_flags[9]  = WINDOW_COMPARE_FLAG;
    raw_flags[10] = CONVERSION_DONE_FLAG;
    raw_flags[11] = COUNTER_ARRAY_FLAG;
    raw_flags[12] = COMPARATOR_ZERO_RISE_FLAG | COMPARATOR_ZERO_FALL_FLAG;
    raw_flags[13] = COMPARATOR_ONE_RISE_FLAG | COMPARATOR_ONE_FALL_FLAG;
    raw_flags[14] = TIMER_THREE_LOW_OVERFLOW | TIMER_THREE_HIGH_OVERFLOW;
  end

  // per-source masks follow the source order above
  always_comb begin
    src_masks = '0;
    src_masks[0]  = state_q.enable_main[imp_pkg::EXT_INPUT_ZERO_BIT];
    src_masks[1]  = state_q.enable_main[imp_pkg::TIMER_ZERO_BIT];
    src_masks[2]  = state_q.enable_main[imp_pkg::EXT_INPUT_ONE_BIT];
    src_masks[3]  = state_q.enable_main[imp_pkg::TIMER_ONE_BIT];
    src_masks[4]  = state_q.enable_main[imp_pkg::UART_ZERO_BIT];
    src_masks[5]  = state_q.enable_main[imp_pkg::TIMER_TWO_BIT];
    src_masks[6]  = state_q.enable_main[imp_pkg::SERIAL_PORT_ZERO_BIT];
    src_masks[7]  = state_q.enable_ext1[imp_pkg::TWO_WIRE_BIT];
    src_masks[8]  = state_q.enable_ext1[imp_pkg::CLOCK_ALARM_BIT];
    src_masks[9]  = state_q.enable_ext1[imp_pkg::WINDOW_COMPARE_BIT];
    src_masks[10] = state_q.enable_ext1[imp_pkg::CONVERSION_DONE_BIT];
    src_masks[11] = state_q.enable_ext1[imp_pkg::COUNTER_ARRAY_BIT];
    src_masks[12] = state_q.enable_ext1[imp_pkg::COMPARATOR_ZERO_BIT];
    src_masks[13] = state_q.enable_ext1[imp_pkg::COMPARATOR_ONE_BIT];
    src_masks[14] = state_q.enable_ext1[imp_pkg::TIMER_THREE_BIT];
  end

  // extended sources have no priority register here, so they sit low
  always_comb begin
    src_high = '0;
    src_high[imp_pkg::MAIN_SOURCES-1:0] = state_q.prio_main;
  end

  imp_src_gate #(
    .N           (NUM_SRC)
  ) u_gate (
    .flags       (raw_flags),
    .masks       (src_masks),
    .global_gate (state_q.enable_main[imp_pkg::GLOBAL_IRQ_GATE_BIT]),
    .requests    (gated)
  );

  imp_prio_pick #(
    .N          (NUM_SRC),
    .ID_W       (ID_W)
  ) u_pick (
    .requests   (gated),
    .high_level (src_high),
    .valid      (pick_valid),
    .source_id  (pick_id),
    .is_high    (pick_high)
  );

  always_comb begin
    state_d = state_q;
    prio_next_view = '0;

    // byte writes; unmapped addresses are ignored
    if (SFR_WR_EN) begin
      case (wr_sel)
        SEL_EN: begin
          state_d.enable_main = SFR_WDATA;
        end
        SEL_PRIO: begin
          state_d.prio_main = SFR_WDATA[6:0];
        end
        SEL_EXT1: begin
          state_d.enable_ext1 = SFR_WDATA;
        end
        default: begin
          state_d.enable_main = state_d.enable_main;
        end
      endcase
    end

    // bit writes land after a same-cycle byte write
    if (SFR_BIT_WR_EN) begin
      case (bsel)
        SEL_EN: begin
          state_d.enable_main[bnum] = SFR_BIT_WDATA;
        end
        SEL_PRIO: begin
          // bit 7 write has no effect
          prio_next_view = {1'b0, state_d.prio_main};
          prio_next_view[bnum] = SFR_BIT_WDATA;
          state_d.prio_main = prio_next_view[6:0];
        end
        default: begin
          state_d.enable_ext1 = state_d.enable_ext1;
        end
      endcase
    end

    // byte read answer, registered; unmapped reads return zero
    state_d.hit   = 1'b0;
    state_d.rdata = imp_pkg::UNMAPPED_READ;
    if (SFR_RD_EN) begin
      case (rd_sel)
        SEL_EN: begin
          state_d.hit   = 1'b1;
          state_d.rdata = state_q.enable_main;
        end
        SEL_PRIO: begin
          state_d.hit   = 1'b1;
          state_d.rdata = prio_view;
        end
        SEL_EXT1: begin
          state_d.hit   = 1'b1;
          state_d.rdata = state_q.enable_ext1;
        end
        default: begin
          state_d.hit   = 1'b0;
        end
      endcase
    end

    // bit read answer, registered
    state_d.bit_hit   = 1'b0;
    state_d.bit_rdata = 1'b0;
    if (SFR_BIT_RD_EN) begin
      case (bsel)
        SEL_EN: begin
          state_d.bit_hit   = 1'b1;
          state_d.bit_rdata = state_q.enable_main[bnum];
        end
        SEL_PRIO: begin
          state_d.bit_hit   = 1'b1;
          state_d.bit_rdata = prio_view[bnum];
        end
        default: begin
          state_d.bit_hit   = 1'b0;
        end
      endcase
    end

    state_d.request    = gated;
    state_d.high       = src_high;
    state_d.valid      = pick_valid;
    state_d.source     = pick_id;
    state_d.high_level = pick_high;
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      state_q             <= '0;
      state_q.enable_main <= imp_pkg::RST_ENABLE_MAIN;
      state_q.prio_main   <= imp_pkg::RST_PRIO_MAIN;
      state_q.enable_ext1 <= imp_pkg::RST_ENABLE_EXT1;
    end else begin
      state_q <= state_d;
    end
  end

  // every output straight from the state register, except PRIO_MAIN bit 7, a fixed one
  assign SFR_RDATA      = state_q.rdata;
  assign SFR_HIT        = state_q.hit;
  assign SFR_BIT_RDATA  = state_q.bit_rdata;
  assign SFR_BIT_HIT    = state_q.bit_hit;
  assign IRQ_REQUEST    = state_q.request;
  assign IRQ_HIGH       = state_q.high;
  assign IRQ_VALID      = state_q.valid;
  assign IRQ_SOURCE     = state_q.source;
  assign IRQ_HIGH_LEVEL = state_q.high_level;
  assign ENABLE_MAIN    = state_q.enable_main;
  assign PRIO_MAIN      = prio_view;
  assign ENABLE_EXT1    = state_q.enable_ext1;

endmodule : imp_regs_top

// File: rtl/imp_src_gate.sv
// per-source mask and global gate for the pending flags
`timescale 1ns/1ps
module imp_src_gate #(
  parameter int unsigned N = 15
) (
  // pending flags and masks
  input  wire logic [N-1:0] flags,
  input  wire logic [N-1:0] masks,
  input  wire logic         global_gate,
  // gated requests
  output logic      [N-1:0] requests
);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_src
      assign requests[g] = global_gate & masks[g] & flags[g];
    end
  endgenerate

endmodule : imp_src_gate

// File: verif/imp_periph_model.sv
// peripheral pending flags: set by events, held until software clears
`timescale 1ns/1ps
module imp_periph_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // events and clears
  input  wire logic [18:0] set_ev,
  input  wire logic [18:0] clr_ev,
  // pending flags
  output logic      [18:0] flags
);
  // sticky, so a request raised while masked is still there later
  always_ff @(posedge clk) begin
    if (rst) begin
      flags <= 19'h00000;
    end else begin
      flags <= (flags & ~clr_ev) | set_ev;
    end
  end
endmodule : imp_periph_model

// File: verif/imp_regs_sva.sv
// checker: timing relations at the interrupt register block ports
`timescale 1ns/1ps
module imp_regs_sva #(
  parameter int unsigned NUM_SRC = 15,
  parameter int unsigned ID_W    = 4
) (
  // clock and reset
  input wire logic               MCLK, SYS_RST,
  // register access
  input wire logic [7:0]         SFR_PAGE, SFR_ADDR, SFR_WDATA, SFR_RDATA,
  input wire logic               SFR_WR_EN, SFR_RD_EN, SFR_HIT,
  input wire logic [7:0]         SFR_BIT_ADDR,
  input wire logic               SFR_BIT_RD_EN, SFR_BIT_HIT,
  // pending flags
  input wire logic EXT_IRQ_INPUT_ZERO, TIMER_ZERO_OVERFLOW, EXT_IRQ_INPUT_ONE,
  input wire logic TIMER_ONE_OVERFLOW, FIRST_UART_FLAG, SERIAL_PORT_ZERO_FLAG,
  input wire logic TIMER_TWO_LOW_OVERFLOW, TIMER_TWO_HIGH_OVERFLOW,
  input wire logic TWO_WIRE_BUS_PORT_FLAG, CLOCK_ALARM_FLAG, COUNTER_ARRAY_FLAG,
  input wire logic WINDOW_COMPARE_FLAG, CONVERSION_DONE_FLAG,
  input wire logic COMPARATOR_ZERO_RISE_FLAG, COMPARATOR_ZERO_FALL_FLAG,
  input wire logic COMPARATOR_ONE_RISE_FLAG, COMPARATOR_ONE_FALL_FLAG,
  input wire logic TIMER_THREE_LOW_OVERFLOW, TIMER_THREE_HIGH_OVERFLOW,
  // requests and register contents
  input wire logic [NUM_SRC-1:0] IRQ_REQUEST, IRQ_HIGH,
  input wire logic               IRQ_VALID, IRQ_HIGH_LEVEL,
  input wire logic [ID_W-1:0]    IRQ_SOURCE,
  input wire logic [7:0]         ENABLE_MAIN, PRIO_MAIN, ENABLE_EXT1
);
  logic [14:0] src;
  logic [14:0] hi;
  logic [14:0] pool;
  logic [3:0]  win;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  // two-flag sources fold into one request
  assign src = {TIMER_THREE_LOW_OVERFLOW | TIMER_THREE_HIGH_OVERFLOW,
    COMPARATOR_ONE_RISE_FLAG | COMPARATOR_ONE_FALL_FLAG,
    COMPARATOR_ZERO_RISE_FLAG | COMPARATOR_ZERO_FALL_FLAG,
    COUNTER_ARRAY_FLAG, CONVERSION_DONE_FLAG, WINDOW_COMPARE_FLAG,
    CLOCK_ALARM_FLAG, TWO_WIRE_BUS_PORT_FLAG, SERIAL_PORT_ZERO_FLAG,
    TIMER_TWO_LOW_OVERFLOW | TIMER_TWO_HIGH_OVERFLOW, FIRST_UART_FLAG,
    TIMER_ONE_OVERFLOW, EXT_IRQ_INPUT_ONE, TIMER_ZERO_OVERFLOW,
    EXT_IRQ_INPUT_ZERO};
  assign hi = IRQ_REQUEST[14:0] & IRQ_HIGH[14:0];
  assign pool = (|hi) ? hi : IRQ_REQUEST[14:0];

  // lowest numbered request of the winning level
  always_comb begin
    win = 4'h0;
    for (int i = 14; i >= 0; i--) begin
      if (pool[i]) begin
        win = 4'(i);
      end
    end
  end

  chk_main_lo: assert property (
    1'b1 |=> IRQ_REQUEST[3:0] ==
      $past(src[3:0] & ENABLE_MAIN[3:0] & {4{ENABLE_MAIN[7]}}))
    else $error("main request bits 3..0 mismatch");
  chk_main_hi: assert property (
    ##1 IRQ_REQUEST[6:4] ==
      $past(src[6:4] & ENABLE_MAIN[6:4] & {3{ENABLE_MAIN[7]}}))
    else $error("main request bits 6..4 mismatch");
  chk_ext_lo: assert property (
    1'b1 |=> IRQ_REQUEST[10:7] ==
      $past(src[10:7] & ENABLE_EXT1[3:0] & {4{ENABLE_MAIN[7]}}))
    else $error("extended request bits 10..7 mismatch");
  chk_ext_hi: assert property (
    1'b1 |=> IRQ_REQUEST[14:11] ==
      $past(src[14:11] & ENABLE_EXT1[7:4] & {4{ENABLE_MAIN[7]}}))
    else $error("extended request bits 14..11 mismatch");
  chk_gate_off: assert property (
    !ENABLE_MAIN[7] |=> !IRQ_VALID && IRQ_REQUEST == '0)
    else $error("request passed with global gate clear");
  chk_prio_top: assert property (
    PRIO_MAIN[7] && $stable(PRIO_MAIN[7]))
    else $error("priority top bit not one");
  chk_level_map: assert property (
    1'b1 |=> IRQ_HIGH[6:0] == $past(PRIO_MAIN[6:0]) && IRQ_HIGH[14:7] == '0)
    else $error("level map mismatch");
  chk_valid_any: assert property (
    IRQ_VALID == (|IRQ_REQUEST))
    else $error("valid does not match requests");
  chk_win_pick: assert property (
    IRQ_VALID |-> IRQ_SOURCE == win && IRQ_HIGH_LEVEL == (|hi))
    else $error("wrong winning source");
  chk_main_read: assert property (
    SFR_RD_EN && SFR_ADDR == imp_pkg::ADDR_ENABLE_MAIN
      |=> SFR_HIT && SFR_RDATA == $past(ENABLE_MAIN))
    else $error("enable main read mismatch");
  chk_prio_page: assert property (
    SFR_RD_EN && SFR_ADDR == imp_pkg::ADDR_PRIO_MAIN && SFR_PAGE != 8'h00
      |=> !SFR_HIT && SFR_RDATA == 8'h00)
    else $error("priority answered off page zero");
  chk_ext_write: assert property (
    SFR_WR_EN && SFR_ADDR == imp_pkg::ADDR_ENABLE_EXT1
      |=> ENABLE_EXT1 == $past(SFR_WDATA))
    else $error("extended enable write lost");
  chk_ext_nobit: assert property (
    SFR_BIT_RD_EN && SFR_BIT_ADDR[7:3] == 5'h1c |=> !SFR_BIT_HIT)
    else $error("bit access answered in extended block");
endmodule : imp_regs_sva

bind imp_regs_top imp_regs_sva #(.NUM_SRC(NUM_SRC), .ID_W(ID_W)) i_sva (.*);

// File: verif/interrupt_mask_priority_regs_tb.sv
// testbench for the interrupt enable and priority register block
`timescale 1ns/1ps
module interrupt_mask_priority_regs_tb;
  logic        MCLK = 1'b0;
  logic        SYS_RST;
  logic [7:0]  page, addr, wdata, baddr, e, p, x, pg;
  logic        wr_en, rd_en, bwr_en, brd_en, bwd;
  logic [18:0] set_ev, clr_ev, f;
  wire  [18:0] fl;
  wire  [7:0]  rdata, en_main, prio, en_ext;
  wire         hit, brdata, bhit, irq_valid, irq_hl;
  wire  [14:0] irq_req, irq_high;
  wire  [3:0]  irq_src;
  logic [31:0] rng_q = 32'h0000003e;
  logic [31:0] r;
  logic [20:0] ex;
  int          error_cnt = 0;
  int          samples_checked = 0;

  always #4 MCLK = ~MCLK;

  imp_regs_top i_dut (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .SFR_PAGE(page), .SFR_ADDR(addr),
    .SFR_WR_EN(wr_en), .SFR_WDATA(wdata), .SFR_RD_EN(rd_en),
    .SFR_RDATA(rdata), .SFR_HIT(hit), .SFR_BIT_ADDR(baddr),
    .SFR_BIT_WR_EN(bwr_en), .SFR_BIT_WDATA(bwd), .SFR_BIT_RD_EN(brd_en),
    .SFR_BIT_RDATA(brdata), .SFR_BIT_HIT(bhit),
    .EXT_IRQ_INPUT_ZERO(fl[0]), .TIMER_ZERO_OVERFLOW(fl[1]),
    .EXT_IRQ_INPUT_ONE(fl[2]), .TIMER_ONE_OVERFLOW(fl[3]),
    .FIRST_UART_FLAG(fl[4]), .TIMER_TWO_LOW_OVERFLOW(fl[5]),
    .TIMER_TWO_HIGH_OVERFLOW(fl[6]), .SERIAL_PORT_ZERO_FLAG(fl[7]),
    .TWO_WIRE_BUS_PORT_FLAG(fl[8]), .CLOCK_ALARM_FLAG(fl[9]),
    .WINDOW_COMPARE_FLAG(fl[10]), .CONVERSION_DONE_FLAG(fl[11]),
    .COUNTER_ARRAY_FLAG(fl[12]), .COMPARATOR_ZERO_RISE_FLAG(fl[13]),
    .COMPARATOR_ZERO_FALL_FLAG(fl[14]), .COMPARATOR_ONE_RISE_FLAG(fl[15]),
    .COMPARATOR_ONE_FALL_FLAG(fl[16]), .TIMER_THREE_LOW_OVERFLOW(fl[17]),
    .TIMER_THREE_HIGH_OVERFLOW(fl[18]), .IRQ_REQUEST(irq_req),
    .IRQ_HIGH(irq_high), .IRQ_VALID(irq_valid), .IRQ_SOURCE(irq_src),
    .IRQ_HIGH_LEVEL(irq_hl), .ENABLE_MAIN(en_main), .PRIO_MAIN(prio),
    .ENABLE_EXT1(en_ext));

  imp_periph_model i_flags (.clk(MCLK), .rst(SYS_RST), .set_ev(set_ev),
    .clr_ev(clr_ev), .flags(fl));

  function automatic logic [31:0] xs();
    rng_q ^= rng_q << 13;
    rng_q ^= rng_q >> 17;
    rng_q ^= rng_q << 5;
    return rng_q;
  endfunction : xs

  // expected {valid, high level, source, requests}
  function automatic logic [20:0] exp_irq(logic [18:0] fv, logic [7:0] ev,
                                          logic [7:0] pv, logic [7:0] xv);
    logic [14:0] s, q, h;
    logic [3:0]  w;
    s = {fv[17] | fv[18], fv[15] | fv[16], fv[13] | fv[14], fv[12:8], fv[7],
         fv[5] | fv[6], fv[4:0]};
    q = s & {xv, ev[6:0]} & {15{ev[7]}};
    h = q & {8'h00, pv[6:0]};
    w = 4'h0;
    for (int i = 14; i >= 0; i--) begin
      if ((|h) ? h[i] : q[i]) begin
        w = 4'(i);
      end
    end
    return {|q, |h, w, q};
  endfunction : exp_irq

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic b, input logic [7:0] pa, input logic [7:0] a,
                    input logic [7:0] d);
    @(posedge MCLK);
    page <= pa;
    addr <= a;
    baddr <= a;
    wdata <= d;
    bwd <= d[0];
    wr_en <= !b;
    bwr_en <= b;
    @(posedge MCLK);
    wr_en <= 1'b0;
    bwr_en <= 1'b0;
  endtask : wr

  // expected is {hit, data}; a bit read gives data in bit 0
  task automatic rd(input logic b, input logic [7:0] pa, input logic [7:0] a,
                    input logic [8:0] exp);
    @(posedge MCLK);
    page <= pa;
    addr <= a;
    baddr <= a;
    rd_en <= !b;
    brd_en <= b;
    @(posedge MCLK);
    rd_en <= 1'b0;
    brd_en <= 1'b0;
    #1;
    chk(b ? 32'({bhit, 7'h00, brdata}) : 32'({hit, rdata}), 32'(exp));
  endtask : rd

  // flags become visible to the block one edge after the event
  task automatic flag_set(input logic [18:0] v);
    @(posedge MCLK);
    set_ev <= v;
    clr_ev <= 19'h7ffff;
    @(posedge MCLK);
    set_ev <= 19'h00000;
    clr_ev <= 19'h00000;
    repeat (2) @(posedge MCLK);
    #1;
  endtask : flag_set

  task automatic do_reset();
    @(posedge MCLK);
    SYS_RST <= 1'b1;
    repeat (3) @(posedge MCLK);
    SYS_RST <= 1'b0;
    #1;
    chk(32'({en_main, prio, en_ext}), 32'h00008000);
  endtask : do_reset

  task automatic results();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  initial begin
    repeat (5000) @(posedge MCLK);
    error_cnt++;
    results();
  end

  initial begin
    {page, addr, wdata, baddr, wr_en, rd_en, bwr_en, brd_en, bwd} = '0;
    {set_ev, clr_ev} = '0;
    SYS_RST = 1'b1;
    do_reset();
    rd(1'b0, 8'h00, 8'hb8, 9'h180);
    for (int n = 0; n < 48; n++) begin
      r = xs();
      {pg, x, p, e} = r;
      r = xs();
      f = r[18:0];
      if (n == 0) begin
        e = 8'h7f;
      end
      if (n < 2) begin
        f = 19'h7ffff;
      end
      if (n == 1) begin
        e = 8'hff;
        x = 8'hff;
        p = 8'h00;
      end
      if (n == 2) begin
        e = 8'ha0;
        p = 8'h20;
        f = 19'h00040;
      end
      wr(1'b0, pg, 8'ha8, e);
      wr(1'b0, 8'h00, 8'hb8, p);
      wr(1'b0, pg, 8'he6, x);
      flag_set(f);
      ex = exp_irq(f, e, p, x);
      chk(32'({irq_valid, irq_hl, irq_src, irq_req}), 32'(ex));
      chk(32'(irq_valid), 32'(ex[20] & e[7]));
      chk(32'(irq_req[3:0]), 32'(ex[3:0]));
      chk(32'(irq_req[6:4]), 32'(ex[6:4]));
      chk(32'(irq_req[10:7]), 32'(ex[10:7]));
      chk(32'(irq_req[14:11]), 32'(ex[14:11]));
      chk(32'(irq_high), {25'h0, p[6:0]});
      rd(1'b0, pg, 8'ha8, {1'b1, e});
      rd(1'b0, 8'h00, 8'hb8, {2'b11, p[6:0]});
      rd(1'b0, pg, 8'he6, {1'b1, x});
    end
    wr(1'b0, 8'h00, 8'ha8, 8'h00);
    wr(1'b0, 8'h00, 8'hb8, 8'h00);
    wr(1'b0, 8'h00, 8'he6, 8'h00);
    wr(1'b1, 8'h00, 8'haf, 8'h01);
    rd(1'b0, 8'h03, 8'ha8, 9'h180);
    rd(1'b1, 8'h07, 8'haf, 9'h101);
    rd(1'b1, 8'h00, 8'ha8, 9'h100);
    wr(1'b1, 8'h00, 8'hba, 8'h01);
    wr(1'b1, 8'h05, 8'hbb, 8'h01);
    wr(1'b1, 8'h00, 8'hbf, 8'h00);
    wr(1'b0, 8'h01, 8'hb8, 8'h7f);
    wr(1'b1, 8'h00, 8'he1, 8'h01);
    rd(1'b0, 8'h00, 8'hb8, 9'h184);
    rd(1'b0, 8'h01, 8'hb8, 9'h000);
    rd(1'b0, 8'h00, 8'he6, 9'h100);
    rd(1'b1, 8'h00, 8'hbf, 9'h101);
    rd(1'b1, 8'h00, 8'hba, 9'h101);
    rd(1'b1, 8'h01, 8'hba, 9'h000);
    rd(1'b1, 8'h00, 8'he6, 9'h000);
    rd(1'b0, 8'h00, 8'h55, 9'h000);
    // byte and bit write in one cycle: the bit write wins for its bit
    @(posedge MCLK);
    {page, addr, baddr, wdata, bwd} <= {8'h00, 8'ha8, 8'hab, 8'h0f, 1'b0};
    wr_en <= 1'b1;
    bwr_en <= 1'b1;
    @(posedge MCLK);
    wr_en <= 1'b0;
    bwr_en <= 1'b0;
    rd(1'b0, 8'h00, 8'ha8, 9'h107);
    do_reset();
    results();
  end
endmodule : interrupt_mask_priority_regs_tb
